/* File: pkg/param_bank_defines.vh */
// Constants for the controller parameter and status bank.
// Assumes inclusion by bare name from design files under verilog/ and from the testbench files.
`ifndef PARAM_BANK_DEFINES_VH
`define PARAM_BANK_DEFINES_VH

// Command codes
`define CMD_APPLY_STORED 8'h00
`define CMD_WORK_BASE 8'h01
`define CMD_PERS_BASE 8'h2B
`define CMD_PERS_LAST 8'h3D
`define CMD_FW_VERSION 8'h6A
`define CMD_SENSOR1 8'h66
`define CMD_ACT_P 8'h67
`define CMD_ACT_I 8'h68
`define CMD_ACT_D 8'h69
// Sensor 2 has no code of its own; placed just after the firmware word
`define CMD_SENSOR2 8'h6B
`define CMD_SENSOR3 8'h7A
`define CMD_CONDITION 8'hC9
`define CMD_FAULT 8'hCA

// Item indices inside a configuration set
`define ITEM_COUNT 19
`define ITEM_CFG 5'h05
`define ITEM_IL 5'h09

// Ranges (signed 16-bit, tenths where the item has a decimal point)
`define IL_MAX 16'h03E7
`define IL_DEFAULT 16'h001A
`define IL_SCALE 16'h000A
`define CFG_AUX_MASK 16'h00C0
`define CFG_ALARM_BIT 16'h0010
`define CFG_LEGAL_MASK 16'h00D0

// Condition word bits
`define COND_AUX_OUT 0
`define COND_AUX_IN 1

// Fault word bits
`define FLT_RANGE1 0
`define FLT_GENERAL 1
`define FLT_NV_WRITE 2
`define FLT_OVER_CUR 3
`define FLT_OT_CTRL 4
`define FLT_OT_S2 5
`define FLT_OT_S3 6
`define FLT_RANGE2 7
`define FLT_RANGE3 8
`define FLT_WATCHDOG 9
`define FLT_CFG_BAD 10
`define FLT_STACK 11

`endif

/* File: testbench/nv_store_model.sv */
// Behavioural nonvolatile store holding the persistent item set.
// Assumes one read or write strobe per cycle from the bank.
`timescale 1ns/1ps
`default_nettype none
module nv_store_model (
  input wire logic i_clock, // System clock
  input wire logic i_rd, // Read strobe
  input wire logic i_wr, // Write strobe
  input wire logic [4:0] i_addr, // Item index
  input wire logic [15:0] i_wdata, // Word to store
  output logic o_rvalid, // Read data valid
  output logic [15:0] o_rdata // Read data
);
  logic [15:0] mem [0:18];
  // Stored set: filter at minimum, aux on with alarm output, limit 26
  initial begin
    for (int i = 0; i < 19; i++) mem[i] = 16'h0000;
    mem[4] = 16'h0001;
    mem[5] = 16'h0050;
    mem[9] = 16'h001A;
  end
  // Idle data flips each cycle so a stale word never passes as fresh
  always @(posedge i_clock) begin
    o_rvalid <= i_rd;
    o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
    if (i_wr) mem[i_addr] <= i_wdata;
  end
endmodule // nv_store_model
`default_nettype wire

/* File: testbench/param_bank_assertions.sv */
// Concurrent checks on the parameter bank's command and store ports.
// Assumes a bind to param_bank; sees only that module's ports.
`include "param_bank_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module param_bank_assertions (
  input wire logic i_clock, i_nrst, // Clock and reset
  input wire logic i_cmd_valid, i_nv_ready, // Command strobe, store idle
  input wire logic [7:0] i_cmd_code, // Command code
  input wire logic [15:0] i_cmd_param, // Parameter
  input wire logic o_rsp_valid, o_rsp_error, o_nv_rd, o_nv_wr, // Strobes
  input wire logic [15:0] o_rsp_data, o_nv_wdata, o_integral_limit, // Words
  input wire logic [4:0] o_nv_addr, // Store index
  input wire logic i_auxiliary_input_flag, i_auxiliary_output_flag, // Aux
  input wire logic [10:0] i_fault_events // Raw faults
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [10:0] ev_q;
  logic [1:0] aux_q;
  // Level inputs one cycle back, to match a one-cycle answer
  always @(posedge i_clock) begin
    ev_q <= i_fault_events;
    aux_q <= {i_auxiliary_input_flag, i_auxiliary_output_flag};
  end
  // ==========================================================
  // Command sequences
  sequence s_read(logic [7:0] code);
    i_cmd_valid && i_cmd_code == code && i_cmd_param == 16'h0000
    ##1 o_rsp_valid && !o_rsp_error;
  endsequence
  sequence s_pers_wr;
    i_cmd_valid && i_cmd_code >= `CMD_PERS_BASE && i_nv_ready
    && i_cmd_code <= `CMD_PERS_LAST && i_cmd_param != 16'h0000;
  endsequence
  a_pers_store: assert property (
    s_pers_wr ##1 (o_rsp_valid && !o_rsp_error) |-> o_nv_wr
    && o_nv_wdata == $past(i_cmd_param)
    && o_nv_addr == $past(i_cmd_code[4:0]) - 5'h0B)
    else $error("persistent write not stored");
  a_err_valid: assert property (o_rsp_error |-> o_rsp_valid)
    else $error("error without answer");
  a_err_no_store: assert property (o_rsp_error |-> !o_nv_wr)
    else $error("refused write reached store");
  a_store_ready: assert property (o_nv_wr |-> $past(i_nv_ready))
    else $error("store written while busy");
  a_limit_scale: assert property (o_integral_limit <= 16'h2706
    && o_integral_limit % 16'h000A == 16'h0000)
    else $error("integral limit not a tenfold value");
  a_reload_start: assert property ($rose(i_nrst) |-> ##[1:40] o_nv_rd)
    else $error("no reload after reset");
  a_cond_word: assert property (s_read(`CMD_CONDITION)
    |-> o_rsp_data[1:0] == ~aux_q)
    else $error("condition word bits wrong");
  a_fault_word: assert property (s_read(`CMD_FAULT)
    |-> {o_rsp_data[15:11], o_rsp_data[9:3], o_rsp_data[1:0]}
    == {4'h0, ev_q[10], ev_q[9:3], ev_q[1:0]})
    else $error("fault word bits wrong");
endmodule // param_bank_assertions
bind param_bank param_bank_assertions u_chk (.i_clock, .i_nrst,
  .i_cmd_valid, .i_nv_ready, .i_cmd_code, .i_cmd_param, .o_rsp_valid,
  .o_rsp_error, .o_nv_rd, .o_nv_wr, .o_rsp_data, .o_nv_wdata,
  .o_integral_limit, .o_nv_addr, .i_auxiliary_input_flag,
  .i_auxiliary_output_flag, .i_fault_events);
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench: host commands against the bank and store model.
// Assumes the checker binds itself to the bank.
`include "param_bank_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] ANY = 16'hFFFF;
  logic i_clock = 1'b0, i_nrst = 1'b0, i_cmd_valid = 1'b0;
  logic [7:0] i_cmd_code = 8'h00;
  logic [15:0] i_cmd_param = 16'h0000, i_sensor1 = 16'h0123;
  logic i_nv_ready = 1'b1, i_nv_crc_ok = 1'b1, i_nv_wr_fail = 1'b0;
  logic i_auxiliary_input_flag = 1'b0, i_auxiliary_output_flag = 1'b0;
  logic [10:0] i_fault_events = 11'h000;
  wire o_rsp_valid, o_rsp_error, o_nv_rd, o_nv_wr, o_aux_alarm_style;
  wire nv_rvalid;
  wire [15:0] o_rsp_data, o_nv_wdata, o_integral_limit, nv_rdata;
  wire [4:0] o_nv_addr;
  wire [1:0] o_aux_function;
  integer n_mismatch = 0, n_compared = 0, cycles = 0, nrd = 0;
  logic w_wr;
  logic [4:0] w_addr;
  logic [15:0] w_wdata;
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  param_bank dut (.i_clock, .i_nrst, .i_cmd_valid, .i_cmd_code,
    .i_cmd_param, .o_rsp_valid, .o_rsp_data, .o_rsp_error, .i_nv_ready,
    .o_nv_rd, .o_nv_wr, .o_nv_addr, .o_nv_wdata, .i_nv_rvalid(nv_rvalid),
    .i_nv_rdata(nv_rdata), .i_nv_crc_ok, .i_nv_wr_fail, .i_sensor1,
    .i_sensor2(~i_sensor1), .i_sensor3(i_sensor1 + 16'h0001),
    .i_act_p(i_sensor1 ^ 16'h00F0), .i_act_i(i_sensor1 ^ 16'h0F00),
    .i_act_d(i_sensor1 ^ 16'hF000), .i_fw_version(i_sensor1 ^ 16'h0101),
    .i_auxiliary_input_flag, .i_auxiliary_output_flag, .i_fault_events,
    .o_aux_function, .o_aux_alarm_style, .o_integral_limit);
  nv_store_model nv (.i_clock, .i_rd(o_nv_rd), .i_wr(o_nv_wr),
    .i_addr(o_nv_addr), .i_wdata(o_nv_wdata), .o_rvalid(nv_rvalid),
    .o_rdata(nv_rdata));
  // ==========================================================
  // Reload counting and hang guard; whole run is well under 5000 cycles
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (o_nv_rd === 1'b1) nrd <= nrd + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report;
    end
  end
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ==========================================================
  // Reset, then wait out the 19-item reload before any command
  task rst(input logic ok);
    @(posedge i_clock);
    i_nrst <= 1'b0;
    i_nv_crc_ok <= ok;
    repeat (6) @(posedge i_clock);
    nrd = 0;
    i_nrst <= 1'b1;
    for (int k = 0; k < 400 && nrd < 19; k++) @(posedge i_clock);
    repeat (4) @(posedge i_clock);
    chk(nrd[15:0], 16'h0013);
  endtask
  // One command; ANY skips the data compare
  task cmd(input logic [7:0] c, input logic [15:0] p,
    input logic [15:0] ed, input logic ee);
    @(posedge i_clock);
    i_cmd_valid <= 1'b1;
    i_cmd_code <= c;
    i_cmd_param <= p;
    @(posedge i_clock);
    i_cmd_valid <= 1'b0;
    #1;
    for (int k = 0; k < 8 && o_rsp_valid !== 1'b1; k++) @(posedge i_clock) #1;
    {w_wr, w_addr, w_wdata} = {o_nv_wr, o_nv_addr, o_nv_wdata};
    chk({14'h0, o_rsp_valid, o_rsp_error}, {14'h0, 1'b1, ee});
    if (ed !== ANY) chk(o_rsp_data, ed);
  endtask
  // ==========================================================
  // Scenarios
  task t_apply;
    chk(o_integral_limit, 16'h0104);
    cmd(8'h30, 16'h0000, 16'h0050, 1'b0);
    cmd(8'h0A, 16'h0064, 16'h0064, 1'b0);
    @(posedge i_clock) #1;
    chk(o_integral_limit, 16'h03E8);
    cmd(`CMD_APPLY_STORED, 16'h0000, ANY, 1'b0);
    @(posedge i_clock) #1;
    chk(o_integral_limit, 16'h0104);
    chk({13'h0, o_aux_function, o_aux_alarm_style}, 16'h0003);
    $display("test apply done");
  endtask
  task t_work;
    cmd(8'h0A, 16'h03E7, 16'h03E7, 1'b0);
    cmd(8'h0A, 16'h03E8, ANY, 1'b1);
    cmd(8'h0A, 16'h0000, 16'h03E7, 1'b0);
    chk(o_integral_limit, 16'h2706);
    cmd(8'h06, 16'h0008, ANY, 1'b1);
    cmd(8'h66, 16'h0000, 16'h0123, 1'b0);
    cmd(`CMD_ACT_P, 16'h0000, 16'h01D3, 1'b0);
    cmd(`CMD_ACT_I, 16'h0000, 16'h0E23, 1'b0);
    cmd(`CMD_ACT_D, 16'h0000, 16'hF123, 1'b0);
    cmd(`CMD_FW_VERSION, 16'h0000, 16'h0022, 1'b0);
    cmd(`CMD_SENSOR2, 16'h0000, 16'hFEDC, 1'b0);
    cmd(`CMD_SENSOR3, 16'h0000, 16'h0124, 1'b0);
    cmd(8'h66, 16'h0005, ANY, 1'b1);
    $display("test working set done");
  endtask
  task t_pers;
    @(posedge i_clock);
    i_nv_ready <= 1'b0;
    cmd(8'h34, 16'h0005, ANY, 1'b1);
    @(posedge i_clock);
    i_nv_ready <= 1'b1;
    cmd(8'h34, 16'h0005, 16'h0005, 1'b0);
    chk({w_wr, w_addr, w_wdata[9:0]}, {1'b1, 5'h09, 10'h005});
    cmd(8'h34, 16'h0000, 16'h0005, 1'b0);
    chk(o_integral_limit, 16'h2706);
    cmd(`CMD_APPLY_STORED, 16'h0000, ANY, 1'b0);
    @(posedge i_clock) #1;
    chk(o_integral_limit, 16'h0032);
    $display("test persistent set done");
  endtask
  task t_status;
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      {i_auxiliary_input_flag, i_auxiliary_output_flag} <= 2'(k);
      cmd(`CMD_CONDITION, 16'h0000, {14'h0, ~2'(k)}, 1'b0);
    end
    for (int k = 0; k < 11; k++) begin
      @(posedge i_clock);
      i_fault_events <= 11'h001 << k;
      cmd(`CMD_FAULT, 16'h0000, 16'h0001 << (k + k / 10), 1'b0);
    end
    @(posedge i_clock);
    i_fault_events <= 11'h000;
    i_nv_wr_fail <= 1'b1;
    @(posedge i_clock);
    i_nv_wr_fail <= 1'b0;
    cmd(`CMD_FAULT, 16'h0000, 16'h0004, 1'b0);
    cmd(`CMD_FAULT, 16'h0001, ANY, 1'b1);
    rst(1'b0);
    cmd(`CMD_FAULT, 16'h0000, 16'h0400, 1'b0);
    cmd(8'h05, 16'h0000, 16'h0001, 1'b0);
    cmd(8'h0A, 16'h0000, 16'h0000, 1'b0);
    $display("test status words done");
  endtask
  initial begin
    rst(1'b1);
    t_apply;
    t_work;
    t_pers;
    t_status;
    final_report;
  end
endmodule // tb_top
`default_nettype wire

/* File: verilog/param_bank.v */
// Parameter and status bank of a temperature controller.
// Assumes a decoded command strobe (code plus parameter) from the serial
// framing logic, and a nonvolatile store reached through a word port.
// How it works
// - A request with parameter zero reads the addressed item.
// - A request with nonzero parameter stores it into the addressed item.
// - Working configuration lives in plain flops, lost at power removal.
// - Persistent set lives in nonvolatile store, reloaded at every power-up.
// - Apply command copies the persistent set into the working set.
// - Runtime variables are a separate set reported read only.
// - Condition word request returns a 16-bit state word.
// - Condition bit 0 is low when auxiliary output is active.
// - Condition bit 1 is low when auxiliary input is active.
// - Fault word carries general, store, current, watchdog, config, stack.
// - Fault word reports sensor range errors in bits 0, 7 and 8.
// - Fault word reports over-temperature in bits 4, 5 and 6.
// - Integral limit accepts 0 to 999, reset value 0 on a bad stored set, used times ten.
// - Auxiliary input function takes one of four choices.
// - Config byte upper bits select aux input, 0x10 selects alarm output.
`include "param_bank_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module param_bank #(
  parameter ITEMS = 19
) (
  input wire i_clock, // 20 MHz system clock
  input wire i_nrst, // Synchronous reset, active low
  input wire i_cmd_valid, // One-cycle command strobe
  input wire [7:0] i_cmd_code, // Command code
  input wire [15:0] i_cmd_param, // Parameter, zero on reads
  output reg o_rsp_valid, // One-cycle answer strobe
  output reg [15:0] o_rsp_data, // Answer value
  output reg o_rsp_error, // Command refused
  input wire i_nv_ready, // Nonvolatile store idle
  output reg o_nv_rd, // Read strobe to store
  output reg o_nv_wr, // Write strobe to store
  output reg [4:0] o_nv_addr, // Item index in store
  output reg [15:0] o_nv_wdata, // Word to store
  input wire i_nv_rvalid, // Read data valid
  input wire [15:0] i_nv_rdata, // Read data
  input wire i_nv_crc_ok, // Stored set checks out
  input wire i_nv_wr_fail, // Store reported a write failure
  input wire [15:0] i_sensor1, // Runtime: sensor 1 reading
  input wire [15:0] i_sensor2, // Runtime: sensor 2 reading
  input wire [15:0] i_sensor3, // Runtime: sensor 3 reading
  input wire [15:0] i_act_p, // Runtime: proportional term
  input wire [15:0] i_act_i, // Runtime: integral term
  input wire [15:0] i_act_d, // Runtime: derivative term
  input wire [15:0] i_fw_version, // Firmware version word
  input wire i_auxiliary_input_flag, // Auxiliary input active
  input wire i_auxiliary_output_flag, // Auxiliary output active
  input wire [10:0] i_fault_events, // Raw fault levels, see fault word
  output reg [1:0] o_aux_function, // Working aux input function
  output reg o_aux_alarm_style, // Working aux output is alarm style
  output reg [15:0] o_integral_limit // Working limit times ten
);

  // ===========================================================
  // States
  localparam S_BOOT = 4'b0001;
  localparam S_LOAD = 4'b0010;
  localparam S_IDLE = 4'b0100;
  localparam S_APPLY = 4'b1000;

  // ===========================================================
  // Storage: working set is volatile flops
  reg [15:0] working_config_set [0:ITEMS-1];
  reg [15:0] persistent_shadow [0:ITEMS-1];
  reg [3:0] state_q;
  reg [4:0] idx_q;
  reg load_issued_q;
  reg cfg_bad_q;
  reg nv_fail_q;
  integer k;

  // Reset value of each item; filter has a floor of one, the rest zero
  function [15:0] reset_value;
    input [4:0] item;
    begin
      reset_value = (item == 5'h04) ? 16'h0001 : 16'h0000;
    end
  endfunction

  // Range check per item, signed tenths; keeps bad writes out
  function in_range;
    input [4:0] item;
    input [15:0] v;
    reg signed [15:0] s;
    begin
      s = v;
      case (item)
        5'h00, 5'h01: in_range = (s >= -16'sd750) && (s <= 16'sd1750);
        5'h02, 5'h03, 5'h0C: in_range = (s >= 0) && (s <= 16'sd99);
        5'h04: in_range = (s >= 1) && (s <= 16'sd50);
        `ITEM_CFG: in_range = ((v & ~`CFG_LEGAL_MASK) == 16'h0000);
        5'h06, 5'h07, 5'h08: in_range = (s >= 0) && (s <= 16'sd63);
        `ITEM_IL: in_range = (v <= `IL_MAX);
        5'h0A: in_range = (s >= 0) && (s <= 16'sd80);
        5'h0B, 5'h11, 5'h12: in_range = (s >= -16'sd99) && (s <= 16'sd99);
        5'h0D: in_range = (s >= -16'sd999) && (s <= 16'sd999);
        5'h0E: in_range = (v <= 16'd9999);
        5'h0F, 5'h10: in_range = (s >= -16'sd999) && (s <= 16'sd1750);
        default: in_range = 1'b0;
      endcase
    end
  endfunction

  // ===========================================================
  // Command decode
  wire is_read = (i_cmd_param == 16'h0000);
  wire in_work = (i_cmd_code >= `CMD_WORK_BASE) &&
                 (i_cmd_code < `CMD_WORK_BASE + ITEMS);
  wire in_pers = (i_cmd_code >= `CMD_PERS_BASE) &&
                 (i_cmd_code <= `CMD_PERS_LAST);
  wire [7:0] work_off = i_cmd_code - `CMD_WORK_BASE;
  wire [7:0] pers_off = i_cmd_code - `CMD_PERS_BASE;
  wire [4:0] work_idx = work_off[4:0];
  wire [4:0] pers_idx = pers_off[4:0];

  // Live status words
  wire [15:0] condition_word = {14'h0000,
    ~i_auxiliary_input_flag, ~i_auxiliary_output_flag};
  // Top four bits are unimplemented and always read zero
  wire [15:0] fault_word = {4'h0,
    i_fault_events[10], cfg_bad_q, i_fault_events[9],
    i_fault_events[8], i_fault_events[7],
    i_fault_events[6], i_fault_events[5], i_fault_events[4],
    i_fault_events[3], i_fault_events[2] | nv_fail_q,
    i_fault_events[1], i_fault_events[0]};

  // ===========================================================
  // Main sequencer: power-up reload, apply, and command service
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      state_q <= S_BOOT;
      idx_q <= 5'h00;
      load_issued_q <= 1'b0;
      cfg_bad_q <= 1'b0;
      nv_fail_q <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 16'h0000;
      o_rsp_error <= 1'b0;
      o_nv_rd <= 1'b0;
      o_nv_wr <= 1'b0;
      o_nv_addr <= 5'h00;
      o_nv_wdata <= 16'h0000;
      for (k = 0; k < ITEMS; k = k + 1) begin
        working_config_set[k] <= 16'h0000;
        persistent_shadow[k] <= 16'h0000;
      end
    end else begin
      o_rsp_valid <= 1'b0;
      o_rsp_error <= 1'b0;
      o_nv_rd <= 1'b0;
      o_nv_wr <= 1'b0;
      if (i_nv_wr_fail) begin
        nv_fail_q <= 1'b1;
      end
      case (state_q)
        // Start reload of the stored set at each power-up
        S_BOOT: begin
          idx_q <= 5'h00;
          load_issued_q <= 1'b0;
          state_q <= S_LOAD;
        end
        // Fetch items one by one from the store
        S_LOAD: begin
          if (!load_issued_q && i_nv_ready) begin
            o_nv_rd <= 1'b1;
            o_nv_addr <= idx_q;
            load_issued_q <= 1'b1;
          end else if (i_nv_rvalid) begin
            load_issued_q <= 1'b0;
            if (in_range(idx_q, i_nv_rdata) && i_nv_crc_ok) begin
              persistent_shadow[idx_q] <= i_nv_rdata;
              working_config_set[idx_q] <= i_nv_rdata;
            end else begin
              persistent_shadow[idx_q] <= reset_value(idx_q);
              working_config_set[idx_q] <= reset_value(idx_q);
              cfg_bad_q <= 1'b1;
            end
            if (idx_q == ITEMS - 1) begin
              state_q <= S_IDLE;
            end else begin
              idx_q <= idx_q + 5'h01;
            end
          end
        end
        // Copy the persistent set into the working set, one cycle
        S_APPLY: begin
          for (k = 0; k < ITEMS; k = k + 1) begin
            working_config_set[k] <= persistent_shadow[k];
          end
          o_rsp_valid <= 1'b1;
          o_rsp_data <= 16'h0000;
          state_q <= S_IDLE;
        end
        S_IDLE: begin
          if (i_cmd_valid) begin
            o_rsp_valid <= 1'b1;
            o_rsp_data <= 16'h0000;
            if (i_cmd_code == `CMD_APPLY_STORED) begin
              o_rsp_valid <= 1'b0;
              state_q <= S_APPLY;
            end else if (in_work) begin
              if (is_read) begin
                o_rsp_data <= working_config_set[work_idx];
              end else if (in_range(work_idx, i_cmd_param)) begin
                working_config_set[work_idx] <= i_cmd_param;
                o_rsp_data <= i_cmd_param;
              end else begin
                o_rsp_error <= 1'b1;
              end
            end else if (in_pers) begin
              if (is_read) begin
                o_rsp_data <= persistent_shadow[pers_idx];
              end else if (in_range(pers_idx, i_cmd_param) && i_nv_ready) begin
                persistent_shadow[pers_idx] <= i_cmd_param;
                o_nv_wr <= 1'b1;
                o_nv_addr <= pers_idx;
                o_nv_wdata <= i_cmd_param;
                o_rsp_data <= i_cmd_param;
              end else begin
                o_rsp_error <= 1'b1;
              end
            end else if (!is_read) begin
              o_rsp_error <= 1'b1;
            end else begin
              // Runtime set and status words are read only
              case (i_cmd_code)
                `CMD_SENSOR1: o_rsp_data <= i_sensor1;
                `CMD_ACT_P: o_rsp_data <= i_act_p;
                `CMD_ACT_I: o_rsp_data <= i_act_i;
                `CMD_ACT_D: o_rsp_data <= i_act_d;
                `CMD_FW_VERSION: o_rsp_data <= i_fw_version;
                `CMD_SENSOR2: o_rsp_data <= i_sensor2;
                `CMD_SENSOR3: o_rsp_data <= i_sensor3;
                `CMD_CONDITION: o_rsp_data <= condition_word;
                `CMD_FAULT: o_rsp_data <= fault_word;
                default: o_rsp_error <= 1'b1;
              endcase
            end
          end
        end
        default: state_q <= S_BOOT;
      endcase
    end
  end

  // ===========================================================
  // Working-set fields that steer the controller
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_aux_function <= 2'b00;
      o_aux_alarm_style <= 1'b0;
      o_integral_limit <= 16'h0000;
    end else begin
      o_aux_function <= working_config_set[`ITEM_CFG][7:6];
      o_aux_alarm_style <= |(working_config_set[`ITEM_CFG] &
                             `CFG_ALARM_BIT);
      o_integral_limit <= working_config_set[`ITEM_IL] * `IL_SCALE;
    end
  end

endmodule // param_bank

`default_nettype wire
